// *** servo_tuning_param_bank.sv ***
// Our own choice: the APB slave port.
`timescale 1ns/100ps
module servo_tuning_param_bank
  import servo_param_pkg::*;
#(
  parameter int COMBO_TICK_CYC = COMBO_UNIT_MS * CLK_KHZ,
  parameter int CLR_TICK_CYC = CLR_UNIT_MS * CLK_KHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire loop_in_t loop_i,
  output loop_out_t loop_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [NREG-1:0][15:0] prm;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [31:0] c_sub;
    logic [7:0] c_units;
    logic [31:0] p_sub;
    logic [7:0] p_units;
    logic p_done;
    loop_out_t lo;
  } st_t;

  st_t s_q;
  st_t s_d;

  // ==========================================================
  // Helpers

  // Map a word index to a slot; NREG means unmapped
  function automatic int slot_of(input logic [9:0] idx);
    int r;
    r = NREG;
    for (int i = 0; i < NREG; i++) begin
      if (REG_IDX[i] == idx) begin
        r = i;
      end
    end
    return r;
  endfunction

  // Range check, including holes inside the printed span
  function automatic logic val_ok(input int sl, input logic [15:0] v);
    logic ok;
    ok = (v >= REG_MIN[sl]) && (v <= REG_MAX[sl]);
    if (sl == S_MODE && v == 16'h0001) begin
      ok = 1'b0;
    end
    if (sl == S_BACKLASH_COMPENSATION && (v % BACKLASH_COMPENSATION_DIGIT) > BACKLASH_COMPENSATION_PULSE_MAX) begin
      ok = 1'b0;
    end
    if (sl == S_SPEED_FILTER_JITTER_CTRL && ((v % SPEED_FILTER_JITTER_CTRL_HUND) / SPEED_FILTER_JITTER_CTRL_DIGIT) > 16'h0001) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // Apply byte strobes to the low half-word
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [15:0] m;
    m = old;
    if (st[0]) begin
      m[7:0] = wd[7:0];
    end
    if (st[1]) begin
      m[15:8] = wd[15:8];
    end
    return m;
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    int sl;
    logic [15:0] wv;
    logic ok;
    logic [2:0] old_m;
    logic [2:0] new_m;
    logic [15:0] fv;
    logic [31:0] err_lim;
    logic c_arm;
    logic p_arm;
    sl = slot_of(paddr[11:2]);
    wv = 16'h0000;
    ok = 1'b0;
    old_m = s_q.prm[S_MODE][2:0];
    new_m = 3'b000;
    fv = 16'h0000;
    err_lim = 32'h0000_0000;
    c_arm = 1'b0;
    p_arm = 1'b0;
    s_d = s_q;

    // Bus: one wait state, then pready for one cycle
    if (sl < NREG) begin
      wv = merge(s_q.prm[sl], pwdata, pstrb);
      ok = val_ok(sl, wv);
    end
    new_m = wv[2:0];
    s_d.pready = psel & penable & ~s_q.pready;
    if (s_d.pready) begin
      s_d.prdata = 32'h0000_0000;
      s_d.pslverr = 1'b0;
      if (paddr[11:2] == STAT_IDX) begin
        s_d.pslverr = pwrite;
        s_d.prdata = {24'h00_0000, s_q.lo.ovs_fault, s_q.lo.err_fault,
                      s_q.lo.combo_out, s_q.p_done, s_q.prm[S_MODE][3:0]};
      end else if (sl < NREG) begin
        s_d.prdata = {16'h0000, s_q.prm[sl]};
        s_d.pslverr = pwrite & ~ok;
      end else begin
        s_d.pslverr = 1'b1;
      end
    end else begin
      s_d.pslverr = 1'b0; // Error flag stands with pready only
    end

    // Write commits at the edge that completes the transfer
    if (psel & penable & s_q.pready & pwrite & (sl < NREG) & ok) begin
      s_d.prm[sl] = wv;
      if (sl == S_MODE) begin
        // Leaving continuous tuning (mode 2 or 4) for fixed ratio mode 3 keeps the inertia
        if ((old_m == TM_PI_CONT || old_m == TM_FF_CONT) && new_m == TM_PI_FIX) begin
          s_d.prm[S_INERTIA] = loop_i.meas_inertia;
        end
        // Tuned results become the manual gains
        if ((old_m == TM_PI_FIX || old_m == TM_FF_FIX) && new_m == TM_MANUAL) begin
          s_d.prm[S_GPOS] = loop_i.meas.pos;
          s_d.prm[S_GSPP] = loop_i.meas.spd_p;
          s_d.prm[S_GSPI] = loop_i.meas.spd_i;
        end
        if (old_m == TM_FF_FIX && new_m == TM_MANUAL) begin
          s_d.prm[S_RLPF] = loop_i.meas.res_lpf;
          s_d.prm[S_AIG] = loop_i.meas.anti_int;
        end
      end
    end

    // Active gains: manual slots in mode 0, loop values otherwise.
    // Manual slots are never touched by continuous tuning, so dropping
    // back to mode 0 from 2 or 4 discards every measured value.
    if (tune_mode_t'(s_q.prm[S_MODE][2:0]) == TM_MANUAL) begin
      s_d.lo.gains = {s_q.prm[S_GPOS], s_q.prm[S_GSPP], s_q.prm[S_GSPI],
                      s_q.prm[S_RLPF], s_q.prm[S_AIG]};
    end else begin
      s_d.lo.gains = loop_i.meas;
    end
    s_d.lo.inertia_ratio = s_q.prm[S_INERTIA];

    // Fault comparisons, each only in its own control modes
    s_d.lo.ovs_fault = (loop_i.ctrl_mode == CM_SPEED) &&
                       (loop_i.motor_speed > s_q.prm[S_OVERSPEED_THRESHOLD]);
    err_lim = {16'h0000, s_q.prm[S_EXCESS_ERROR_THRESHOLD]};
    if (s_q.prm[S_ESCALE][0]) begin
      err_lim = 32'({16'h0000, s_q.prm[S_EXCESS_ERROR_THRESHOLD]} * ERR_SCALE_MULT);
    end
    s_d.lo.err_fault = (loop_i.ctrl_mode == CM_PULSE_TRAIN ||
                        loop_i.ctrl_mode == CM_REG_POS) &&
                       (loop_i.pos_dev > err_lim);

    // Selected stored-position speed, zero outside register mode
    s_d.lo.move_speed = 16'h0000;
    if (loop_i.ctrl_mode == CM_REG_POS) begin
      s_d.lo.move_speed = s_q.prm[S_MOVE_SPEED_POS1 + int'(loop_i.pos_sel)];
    end

    // Combination output delay; restarts when positioning drops
    c_arm = s_q.prm[S_DOM][0] & loop_i.pos_done;
    if (!c_arm) begin
      s_d.c_sub = 32'h0000_0000;
      s_d.c_units = 8'h00;
      s_d.lo.combo_out = 1'b0;
    end else if (!s_q.lo.combo_out) begin
      if (s_q.c_units == s_q.prm[S_DOD][7:0]) begin
        s_d.lo.combo_out = 1'b1;
      end else if (s_q.c_sub == 32'(COMBO_TICK_CYC - 1)) begin
        s_d.c_sub = 32'h0000_0000;
        s_d.c_units = s_q.c_units + 8'h01;
      end else begin
        s_d.c_sub = s_q.c_sub + 32'h0000_0001;
      end
    end

    // Digital outputs: per-pin functions or the position index
    if (s_q.prm[S_DOM][0]) begin
      s_d.lo.dout = {1'b0, s_q.lo.combo_out, loop_i.pos_sel};
    end else begin
      s_d.lo.dout = loop_i.func_do;
    end

    // Deviation clear: one pulse per request after the delay;
    // a zero setting disables it
    p_arm = loop_i.clr_req && (s_q.prm[S_PED] != 16'h0000);
    s_d.lo.dev_clr = 1'b0;
    if (!p_arm) begin
      s_d.p_sub = 32'h0000_0000;
      s_d.p_units = 8'h00;
      s_d.p_done = 1'b0;
    end else if (!s_q.p_done) begin
      if (s_q.p_units == s_q.prm[S_PED][7:0]) begin
        s_d.lo.dev_clr = 1'b1;
        s_d.p_done = 1'b1;
      end else if (s_q.p_sub == 32'(CLR_TICK_CYC - 1)) begin
        s_d.p_sub = 32'h0000_0000;
        s_d.p_units = s_q.p_units + 8'h01;
      end else begin
        s_d.p_sub = s_q.p_sub + 32'h0000_0001;
      end
    end

    // Backlash: pulse field times gear, upper digit is polarity
    fv = s_q.prm[S_BACKLASH_COMPENSATION] % BACKLASH_COMPENSATION_DIGIT;
    s_d.lo.backlash_compensation_pulses = 32'({16'h0000, fv} * {16'h0000, loop_i.gear});
    s_d.lo.backlash_compensation_rev = s_q.prm[S_BACKLASH_COMPENSATION] >= BACKLASH_COMPENSATION_DIGIT;

    // Feed steps, held in range by the write check
    s_d.lo.feed_steps = s_q.prm[S_FSN][5:0];

    // Input filter digits
    fv = s_q.prm[S_INF] % INF_DIGIT;
    s_d.lo.inf_speed = fv[3:0];
    s_d.lo.inf_en = s_q.prm[S_INF] >= INF_DIGIT;

    // Speed filter, jitter and smoothing digits
    fv = s_q.prm[S_SPEED_FILTER_JITTER_CTRL] % SPEED_FILTER_JITTER_CTRL_DIGIT;
    s_d.lo.spd_lpf_sel = fv[3:0];
    s_d.lo.spd_lpf_hz = LPF_HZ[fv[3:0]];
    fv = (s_q.prm[S_SPEED_FILTER_JITTER_CTRL] % SPEED_FILTER_JITTER_CTRL_HUND) / SPEED_FILTER_JITTER_CTRL_DIGIT;
    s_d.lo.jitter_en = fv[0];
    s_d.lo.smooth_en = s_q.prm[S_SPEED_FILTER_JITTER_CTRL] >= SPEED_FILTER_JITTER_CTRL_HUND;
  end

  // ==========================================================
  // State register; outputs all come from it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.prm <= REG_RST;
      s_q.lo.gains.res_lpf <= REG_RST[S_RLPF];
      s_q.lo.feed_steps <= REG_RST[S_FSN][5:0];
    end else begin
      s_q <= s_d;
    end
  end

  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign loop_o = s_q.lo;

endmodule

// *** servo_param_pkg.sv ***
package servo_param_pkg;
  // ==========================================================
  // Register slots
  localparam int NREG = 25;
  localparam int S_MODE = 0;
  localparam int S_INF = 1;
  localparam int S_OVERSPEED_THRESHOLD = 2;
  localparam int S_EXCESS_ERROR_THRESHOLD = 3;
  localparam int S_MOVE_SPEED_POS1 = 4;
  localparam int S_DOM = 12;
  localparam int S_DOD = 13;
  localparam int S_FSN = 14;
  localparam int S_PED = 15;
  localparam int S_BACKLASH_COMPENSATION = 16;
  localparam int S_SPEED_FILTER_JITTER_CTRL = 17;
  localparam int S_INERTIA = 18;
  localparam int S_GPOS = 19;
  localparam int S_GSPP = 20;
  localparam int S_GSPI = 21;
  localparam int S_RLPF = 22;
  localparam int S_AIG = 23;
  localparam int S_ESCALE = 24;
  localparam logic [9:0] STAT_IDX = 10'h2F8;
  // Word index of each slot, slot 24 first
  localparam logic [NREG-1:0][9:0] REG_IDX = {
    10'h2F6, 10'h2F5, 10'h2F4, 10'h2F3, 10'h2F2, 10'h2F1, 10'h2F0,
    10'h231, 10'h230, 10'h22F, 10'h22E, 10'h22D, 10'h22C,
    10'h22B, 10'h22A, 10'h229, 10'h228, 10'h227, 10'h226, 10'h225, 10'h224,
    10'h223, 10'h222, 10'h221, 10'h220};
  localparam logic [NREG-1:0][15:0] REG_RST = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0006, 16'h0001, 16'h0000,
    {8{16'h03E8}}, 16'h7530, 16'h1388, 16'h0000, 16'h0000};
  localparam logic [NREG-1:0][15:0] REG_MIN = {
    {7{16'h0000}}, 16'h0000, 16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0000,
    {8{16'h0001}}, 16'h0001, 16'h0001, 16'h0000, 16'h0000};
  localparam logic [NREG-1:0][15:0] REG_MAX = {
    16'h0001, 16'h7530, 16'h03E8, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'h0077, 16'h2848, 16'h00FA, 16'h0020, 16'h00FA, 16'h0001,
    {8{16'h1388}}, 16'h7530, 16'h1388, 16'h0013, 16'h0005};
  // ==========================================================
  // Digit fields and scales
  localparam logic [15:0] INF_DIGIT = 16'h000A;
  localparam logic [15:0] SPEED_FILTER_JITTER_CTRL_DIGIT = 16'h000A;
  localparam logic [15:0] SPEED_FILTER_JITTER_CTRL_HUND = 16'h0064;
  localparam logic [15:0] BACKLASH_COMPENSATION_DIGIT = 16'h2710;
  localparam logic [15:0] BACKLASH_COMPENSATION_PULSE_MAX = 16'h0138;
  localparam logic [31:0] ERR_SCALE_MULT = 32'h0000_0064;
  // Speed detection cutoff in Hz per filter code, code 9 first
  localparam logic [9:0][9:0] LPF_HZ = {
    10'h050, 10'h064, 10'h096, 10'h0C8, 10'h0FA,
    10'h12C, 10'h15E, 10'h190, 10'h1C2, 10'h1F4};
  // ==========================================================
  // Timing
  localparam int CLK_KHZ = 200000;
  localparam int COMBO_UNIT_MS = 4;
  localparam int CLR_UNIT_MS = 20;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    TM_MANUAL = 3'b000,
    TM_PI_CONT = 3'b010,
    TM_PI_FIX = 3'b011,
    TM_FF_CONT = 3'b100,
    TM_FF_FIX = 3'b101
  } tune_mode_t;
  typedef enum logic [1:0] {
    CM_SPEED = 2'b00,
    CM_PULSE_TRAIN = 2'b01,
    CM_REG_POS = 2'b10,
    CM_OTHER = 2'b11
  } ctrl_mode_t;
  typedef struct packed {
    logic [15:0] pos;
    logic [15:0] spd_p;
    logic [15:0] spd_i;
    logic [15:0] res_lpf;
    logic [15:0] anti_int;
  } gains_t;
  typedef struct packed {
    ctrl_mode_t ctrl_mode;
    logic [15:0] motor_speed;
    logic [31:0] pos_dev;
    logic [15:0] meas_inertia;
    gains_t meas;
    logic pos_done;
    logic clr_req;
    logic [2:0] pos_sel;
    logic [4:0] func_do;
    logic [15:0] gear;
  } loop_in_t;
  typedef struct packed {
    gains_t gains;
    logic [15:0] inertia_ratio;
    logic ovs_fault;
    logic err_fault;
    logic [15:0] move_speed;
    logic [4:0] dout;
    logic combo_out;
    logic dev_clr;
    logic [31:0] backlash_compensation_pulses;
    logic backlash_compensation_rev;
    logic [5:0] feed_steps;
    logic inf_en;
    logic [3:0] inf_speed;
    logic [3:0] spd_lpf_sel;
    logic [9:0] spd_lpf_hz;
    logic jitter_en;
    logic smooth_en;
  } loop_out_t;
endpackage

// *** servo_param_chk.sv ***
`timescale 1ns/100ps
// ==========================================================
// Port-level checks of the parameter bank
module servo_param_chk
  import servo_param_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire loop_in_t loop_i,
  input wire loop_out_t loop_o
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // Bus answer shape
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  AST_ONE_WAIT: assert property ($rose(penable) && psel |=> pready)
    else $error("pready did not follow the first access cycle");
  AST_REFUSED_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  // ==========================================================
  // Loop outputs against their causes
  AST_OVS_ONLY_SPEED: assert property (loop_i.ctrl_mode != CM_SPEED |=> !loop_o.ovs_fault)
    else $error("overspeed fault outside speed mode");
  AST_ERR_ONLY_POS: assert property (
    loop_i.ctrl_mode inside {CM_SPEED, CM_OTHER} |=> !loop_o.err_fault)
    else $error("deviation fault outside position modes");
  AST_SPEED_SEL: assert property (
    loop_i.ctrl_mode != CM_REG_POS |=> loop_o.move_speed == 16'h0)
    else $error("move speed outside register position mode");
  // Index pins carry the combination output as it stood one cycle earlier
  AST_DOUT_SRC: assert property (
    1'b1 |=> loop_o.dout == $past(loop_i.func_do) ||
      loop_o.dout == {1'b0, $past(loop_o.combo_out), $past(loop_i.pos_sel)})
    else $error("digital outputs from neither source");
  AST_COMBO_DROP: assert property (!loop_i.pos_done |=> !loop_o.combo_out)
    else $error("combination output held without positioning done");
  AST_CLR_PULSE: assert property (loop_o.dev_clr |=> !loop_o.dev_clr)
    else $error("deviation clear longer than one cycle");
  AST_FEED_RANGE: assert property (
    loop_o.feed_steps >= 6'd2 && loop_o.feed_steps <= 6'd32)
    else $error("feed step count out of range");
  AST_INF_SPEED: assert property (loop_o.inf_speed <= 4'd9)
    else $error("input filter speed digit out of range");
  AST_LPF_SEL: assert property (loop_o.spd_lpf_sel <= 4'd9)
    else $error("speed filter code out of range");
endmodule

bind servo_tuning_param_bank servo_param_chk u_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .loop_i(loop_i), .loop_o(loop_o));

// *** loop_model.sv ***
`timescale 1ns/100ps
// ==========================================================
// Motor loop stand-in: measured values and gear ratio
module loop_model
  import servo_param_pkg::*;
(
  input wire loop_in_t cmd,
  output loop_in_t loop_i
);
  // Measurements stand still so every tuning copy can be predicted
  always_comb begin
    loop_i = cmd;
    loop_i.meas_inertia = 16'h0055;
    loop_i.meas = {16'h0011, 16'h0022, 16'h0033, 16'h0044, 16'h0055};
    loop_i.gear = 16'h0002; // Small ratio keeps pulse products easy to read
  end
endmodule

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
  import servo_param_pkg::*;
  localparam logic [9:0] A_MODE = 10'h220, A_INF = 10'h221, A_OVERSPEED_THRESHOLD = 10'h222, A_EXCESS_ERROR_THRESHOLD = 10'h223;
  localparam logic [9:0] A_POV = 10'h224, A_DOM = 10'h22C, A_DOD = 10'h22D, A_FSN = 10'h22E;
  localparam logic [9:0] A_PED = 10'h22F, A_BACKLASH_COMPENSATION = 10'h230, A_SPEED_FILTER_JITTER_CTRL = 10'h231, A_INER = 10'h2F0;
  localparam logic [9:0] A_GPOS = 10'h2F1, A_RLPF = 10'h2F4, A_AIG = 10'h2F5, A_SCALE = 10'h2F6;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, re;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = '0;
  logic [15:0] rv;
  loop_in_t cmd = '0, loop_i;
  loop_out_t loop_o;
  int error_cnt = 0, n_compared = 0, cyc = 0;

  // Clock, 5 ns period
  always #2.5 clk = ~clk;
  loop_model pm (.cmd(cmd), .loop_i(loop_i));
  // Short tick counts keep the timed outputs inside a brief run
  servo_tuning_param_bank #(.COMBO_TICK_CYC(4), .CLR_TICK_CYC(8)) uut (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .loop_i(loop_i),
    .loop_o(loop_o));

  // ==========================================================
  // Reporting
  task test_done;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // ==========================================================
  // Bus cycles: hold the request until pready is seen at an edge
  task apb(input logic w, input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= {16'h0000, d};
    pstrb <= 4'hF;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata[15:0];
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [9:0] a, input logic [15:0] d, input logic ee);
    apb(1'b1, a, d);
    chk($sformatf("pslverr %h", a), {31'h0, ee}, {31'h0, re});
  endtask
  task rd(input logic [9:0] a, input logic [15:0] ex);
    apb(1'b0, a, 16'h0000);
    chk($sformatf("reg %h", a), {16'h0, ex}, {16'h0, rv});
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    rd(A_OVERSPEED_THRESHOLD, 16'h1388);
    rd(A_EXCESS_ERROR_THRESHOLD, 16'h7530);
    for (int i = 0; i < 8; i++) rd(A_POV + 10'(i), 16'h03E8);
    rd(A_DOD, 16'h0001);
    rd(A_FSN, 16'h0006);
    rd(A_PED, 16'h0000);
    rd(A_BACKLASH_COMPENSATION, 16'h0000);
    rd(10'h3FF, 16'h0000);
    wr(10'h3FF, 16'h0001, 1'b1);
  endtask
  task t_range;
    wr(A_FSN, 16'h0021, 1'b1);
    wr(A_FSN, 16'h0001, 1'b1);
    rd(A_FSN, 16'h0006);
    wr(A_FSN, 16'h0020, 1'b0);
    wr(A_OVERSPEED_THRESHOLD, 16'h0000, 1'b1);
    wr(A_INF, 16'h0014, 1'b1);
    wr(A_INF, 16'h0013, 1'b0);
    wr(A_SPEED_FILTER_JITTER_CTRL, 16'h0013, 1'b0);
    wr(A_BACKLASH_COMPENSATION, 16'h0139, 1'b1);
    wr(A_BACKLASH_COMPENSATION, 16'h2848, 1'b0);
    // Idle gap stands in for the homing run owed after a backlash change
    step(2);
    chk("inf_en", 1, loop_o.inf_en);
    chk("inf_speed", 9, loop_o.inf_speed);
    chk("jitter_en", 1, loop_o.jitter_en);
    chk("spd_lpf_hz", 32'h50, loop_o.spd_lpf_hz);
    chk("spd_lpf_sel", 9, loop_o.spd_lpf_sel);
    chk("backlash_compensation_pulses", 32'h270, loop_o.backlash_compensation_pulses);
    chk("backlash_compensation_rev", 1, loop_o.backlash_compensation_rev);
    chk("feed_steps", 32, loop_o.feed_steps);
  endtask
  task t_tune;
    wr(A_MODE, 16'h0001, 1'b1);
    wr(A_MODE, 16'h0002, 1'b0);
    wr(A_MODE, 16'h0003, 1'b0);
    rd(A_INER, 16'h0055);
    wr(A_MODE, 16'h0000, 1'b0);
    rd(A_GPOS, 16'h0011);
    rd(A_GPOS + 10'h1, 16'h0022);
    rd(A_RLPF, 16'h0000);
    wr(A_INER, 16'h0020, 1'b0);
    wr(A_MODE, 16'h0005, 1'b0);
    wr(A_MODE, 16'h0000, 1'b0);
    rd(A_RLPF, 16'h0044);
    rd(A_AIG, 16'h0055);
    wr(A_GPOS, 16'h0077, 1'b0);
    wr(A_MODE, 16'h0004, 1'b0);
    wr(A_MODE, 16'h0000, 1'b0);
    rd(A_GPOS, 16'h0077);
    step(2);
    chk("gains.pos", 16'h0077, loop_o.gains.pos);
    chk("inertia_ratio", 16'h0020, loop_o.inertia_ratio);
  endtask
  task t_fault;
    wr(A_OVERSPEED_THRESHOLD, 16'h0064, 1'b0);
    wr(A_EXCESS_ERROR_THRESHOLD, 16'h000A, 1'b0);
    @(posedge clk);
    cmd.ctrl_mode <= CM_SPEED;
    cmd.motor_speed <= 16'h0065;
    cmd.pos_dev <= 32'h0000_000B;
    step(2);
    chk("ovs_fault", 1, loop_o.ovs_fault);
    chk("err_fault", 0, loop_o.err_fault);
    @(posedge clk);
    cmd.motor_speed <= 16'h0064;
    cmd.ctrl_mode <= CM_PULSE_TRAIN;
    step(2);
    chk("ovs_fault", 0, loop_o.ovs_fault);
    chk("err_fault", 1, loop_o.err_fault);
    wr(A_SCALE, 16'h0001, 1'b0);
    step(2);
    chk("err_fault", 0, loop_o.err_fault);
  endtask
  task t_combo;
    int n;
    wr(A_DOM, 16'h0001, 1'b0);
    wr(A_DOD, 16'h0002, 1'b0);
    wr(A_POV + 10'h3, 16'h0BB8, 1'b0);
    wr(A_PED, 16'h0001, 1'b0);
    @(posedge clk);
    cmd.ctrl_mode <= CM_REG_POS;
    cmd.pos_sel <= 3'd3;
    cmd.pos_done <= 1'b1;
    cmd.clr_req <= 1'b1;
    n = 0;
    do begin
      step(1);
      n++;
    end while (loop_o.combo_out !== 1'b1 && n < 40);
    chk("combo delay", 9, n);
    chk("dev_clr", 1, loop_o.dev_clr);
    chk("move_speed", 16'h0BB8, loop_o.move_speed);
    // Index pins pick up the combination output one cycle after it rises
    step(1);
    chk("dout combo", 5'h0B, loop_o.dout);
    rd(10'h2F8, 16'h0030);
    @(posedge clk);
    cmd.pos_done <= 1'b0;
    cmd.func_do <= 5'h15;
    wr(A_DOM, 16'h0000, 1'b0);
    step(2);
    chk("dout func", 5'h15, loop_o.dout);
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done;
    end
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_range;
    t_tune;
    t_fault;
    t_combo;
    test_done;
  end
endmodule
